// *** fwsb_pkg.sv ***
// fwsb_pkg: constants and types for the flash write-status polling controller
// assumes a 20 MHz system clock and an 8-bit parallel flash on the far side
package fwsb_pkg;
  localparam int          FWSB_CLK_MHZ      = 20;
  localparam int          FWSB_AW           = 18;
  localparam int          FWSB_DW           = 8;
  // data bus bit positions of the status bits
  localparam int          FWSB_POLL_POS     = 7;
  localparam int          FWSB_TOG1_POS     = 6;
  localparam int          FWSB_TMO_POS      = 5;
  localparam int          FWSB_TOG2_POS     = 2;
  // strobe phase lengths in ns and cycles
  localparam int          FWSB_T_ACC_NS     = 100;
  localparam int          FWSB_ACC_CYC      = (FWSB_T_ACC_NS * FWSB_CLK_MHZ + 999) / 1000;
  localparam int          FWSB_T_WP_NS      = 100;
  localparam int          FWSB_WP_CYC       = (FWSB_T_WP_NS * FWSB_CLK_MHZ + 999) / 1000;
  localparam int          FWSB_T_REC_NS     = 50;
  localparam int          FWSB_REC_CYC      = (FWSB_T_REC_NS * FWSB_CLK_MHZ + 999) / 1000;
  localparam logic [3:0]  FWSB_CNT_W0       = 4'h0;
  // operation kinds
  typedef enum logic [1:0] {FWSB_OP_READ, FWSB_OP_WRITE, FWSB_OP_POLL_PROG, FWSB_OP_POLL_ERASE} fwsb_op_t;
  // result codes
  typedef enum logic [1:0] {FWSB_RES_DONE, FWSB_RES_FAIL, FWSB_RES_SUSP} fwsb_res_t;
endpackage : fwsb_pkg

// *** fwsb_bus_if.sv ***
// fwsb_bus_if: read/write requests held until a one-cycle done, between sequencer and strobe engine
// assumes both ends on the same clock
`timescale 1ns/1ps
interface fwsb_bus_if;
  logic                       req;
  logic                       wr;
  logic [fwsb_pkg::FWSB_AW-1:0] addr;
  logic [fwsb_pkg::FWSB_DW-1:0] wdata;
  logic                       done;
  logic [fwsb_pkg::FWSB_DW-1:0] rdata;
  modport master (output req, output wr, output addr, output wdata, input done, input rdata);
  modport slave  (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : fwsb_bus_if

// *** fwsb_strobe.sv ***
// fwsb_strobe: runs one flash bus cycle with chip, output and write strobes
// assumes the flash data bus is shared, driven here only during writes
`timescale 1ns/1ps
module fwsb_strobe
  import fwsb_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // request side
  fwsb_bus_if.slave             bus,
  // flash pins
  output logic [FWSB_AW-1:0]    fa,
  output logic                  ce_n,
  output logic                  oe_n,
  output logic                  we_n,
  output logic [FWSB_DW-1:0]    dq_o,
  output logic                  dq_oe,
  input  wire logic [FWSB_DW-1:0] dq_i
);
  typedef enum logic [1:0] {FWSB_ST_IDLE, FWSB_ST_STRB, FWSB_ST_REC} fwsb_st_t;
  fwsb_st_t            st_r, st_nxt;
  logic [3:0]          cnt_r, cnt_nxt;
  logic                wr_r;
  logic [FWSB_DW-1:0]  rdata_r;
  wire  [3:0]          strb_len = wr_r ? 4'(FWSB_WP_CYC) : 4'(FWSB_ACC_CYC);
  wire                 strb_end = (st_r == FWSB_ST_STRB) && (cnt_r == strb_len - 4'h1);
  wire                 rec_end  = (st_r == FWSB_ST_REC) && (cnt_r == 4'(FWSB_REC_CYC) - 4'h1);

  // next state of the strobe cycle
  always_comb
  begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r + 4'h1;
    case (st_r)
      FWSB_ST_IDLE:
      begin
        cnt_nxt = FWSB_CNT_W0;
        if (bus.req)
          st_nxt = FWSB_ST_STRB;
      end
      FWSB_ST_STRB:
        if (strb_end)
        begin
          st_nxt  = FWSB_ST_REC;
          cnt_nxt = FWSB_CNT_W0;
        end
      FWSB_ST_REC:
        if (rec_end)
          st_nxt = FWSB_ST_IDLE;
      default:
        st_nxt = FWSB_ST_IDLE;
    endcase
  end

  // state, captured request and sampled data
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r    <= FWSB_ST_IDLE;
      cnt_r   <= FWSB_CNT_W0;
      wr_r    <= 1'b0;
      fa      <= '0;
      dq_o    <= '0;
      rdata_r <= '0;
    end
    else
    begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      if (st_r == FWSB_ST_IDLE && bus.req)
      begin
        wr_r <= bus.wr;
        fa   <= bus.addr;
        dq_o <= bus.wdata;
      end
      if (strb_end && !wr_r)
        rdata_r <= dq_i; // each read is one full strobe, so toggle bits advance
    end
  end

  // strobes; write data latches on the rising write strobe
  assign ce_n      = !(st_r == FWSB_ST_STRB);
  assign oe_n      = !(st_r == FWSB_ST_STRB && !wr_r);
  assign we_n      = !(st_r == FWSB_ST_STRB && wr_r);
  assign dq_oe     = (st_r != FWSB_ST_IDLE) && wr_r;
  assign bus.done  = rec_end;
  assign bus.rdata = rdata_r;
endmodule : fwsb_strobe

// *** fwsb_ctrl.sv ***
// fwsb_ctrl: host controller that reads, writes and polls a parallel flash
// assumes the flash answers within the access time and status rules hold
//
// How it works
// - program polling reads at the address being programmed
// - erase polling reads inside a selected, unprotected sector
// - after bit seven turns true, data is taken on a later read
// - host combines both toggle bits for mode and sector selection
// - after timeout flag is one, data polling bit is read again
`timescale 1ns/1ps
module fwsb_ctrl
  import fwsb_pkg::*;
(
  // clock and reset
  input  wire logic                 CLK_SYS,
  input  wire logic                 RESET,
  // user order
  input  wire logic                 START,
  input  wire fwsb_pkg::fwsb_op_t   OP,
  input  wire logic [fwsb_pkg::FWSB_AW-1:0] ADDR,
  input  wire logic [fwsb_pkg::FWSB_DW-1:0] WDATA,
  output logic                      BUSY,
  output logic                      DONE,
  output fwsb_pkg::fwsb_res_t       RESULT,
  output logic [fwsb_pkg::FWSB_DW-1:0] RDATA,
  output logic                      ERASE_ACTIVE,
  output logic                      SECTOR_SELECTED,
  // flash pins
  output logic [fwsb_pkg::FWSB_AW-1:0] FA,
  output logic                      CE_N,
  output logic                      OE_N,
  output logic                      WE_N,
  output logic [fwsb_pkg::FWSB_DW-1:0] DQ_O,
  output logic                      DQ_OE,
  input  wire logic [fwsb_pkg::FWSB_DW-1:0] DQ_I
);
  import fwsb_pkg::*;

  typedef enum logic [2:0] {FWSB_C_IDLE, FWSB_C_ACC, FWSB_C_FIRST, FWSB_C_POLL, FWSB_C_RECHK,
                            FWSB_C_FINAL, FWSB_C_END} fwsb_cst_t;

  fwsb_bus_if bus ();

  fwsb_cst_t           st_r, st_nxt;
  fwsb_op_t            op_r;
  logic [FWSB_AW-1:0]  addr_r;
  logic [FWSB_DW-1:0]  wdata_r;
  logic [FWSB_DW-1:0]  prev_r;
  logic                have_prev_r;
  fwsb_res_t           res_r, res_nxt;
  logic                act_r;
  logic                sel_r;

  // true when polling bit matches the expected completed value
  function automatic logic poll_true(input fwsb_op_t op, input logic [FWSB_DW-1:0] d,
                                     input logic [FWSB_DW-1:0] w);
    if (op == FWSB_OP_POLL_ERASE)
      poll_true = d[FWSB_POLL_POS];
    else
      poll_true = (d[FWSB_POLL_POS] == w[FWSB_POLL_POS]);
  endfunction : poll_true

  // decode of the latest read against the previous one
  wire [FWSB_DW-1:0]   rd       = bus.rdata;
  wire                 is_poll  = (op_r == FWSB_OP_POLL_PROG) || (op_r == FWSB_OP_POLL_ERASE);
  wire                 pdone    = poll_true(op_r, rd, wdata_r);
  wire                 tmo      = rd[FWSB_TMO_POS];
  wire                 tog1     = have_prev_r && (rd[FWSB_TOG1_POS] != prev_r[FWSB_TOG1_POS]);
  wire                 tog2     = have_prev_r && (rd[FWSB_TOG2_POS] != prev_r[FWSB_TOG2_POS]);
  // erase polled true but second toggle still moving means suspended
  wire                 susp     = (op_r == FWSB_OP_POLL_ERASE) && pdone && !tog1 && tog2;

  // bus request whenever a read or write is pending
  assign bus.req   = (st_r == FWSB_C_ACC) || (st_r == FWSB_C_FIRST) || (st_r == FWSB_C_POLL)
                     || (st_r == FWSB_C_RECHK) || (st_r == FWSB_C_FINAL);
  assign bus.wr    = (st_r == FWSB_C_ACC) && (op_r == FWSB_OP_WRITE);
  assign bus.addr  = addr_r;
  assign bus.wdata = wdata_r;

  // sequencing of accesses and polling decisions
  always_comb
  begin
    st_nxt  = st_r;
    res_nxt = res_r;
    case (st_r)
      FWSB_C_IDLE:
        if (START)
        begin
          res_nxt = FWSB_RES_DONE;
          st_nxt  = (OP == FWSB_OP_POLL_PROG || OP == FWSB_OP_POLL_ERASE) ? FWSB_C_FIRST : FWSB_C_ACC;
        end
      FWSB_C_ACC:
        if (bus.done)
          st_nxt = FWSB_C_END;
      // two reads needed before toggling can be judged
      FWSB_C_FIRST:
        if (bus.done)
          st_nxt = FWSB_C_POLL;
      FWSB_C_POLL:
        if (bus.done)
        begin
          if (susp)
          begin
            res_nxt = FWSB_RES_SUSP;
            st_nxt  = FWSB_C_END;
          end
          else if (pdone && !tog1)
            st_nxt = FWSB_C_FINAL;
          else if (tmo)
            st_nxt = FWSB_C_RECHK;
        end
      FWSB_C_RECHK:
        if (bus.done)
        begin
          if (pdone && !tog1)
            st_nxt = FWSB_C_FINAL;
          else
          begin
            res_nxt = FWSB_RES_FAIL;
            st_nxt  = FWSB_C_END;
          end
        end
      // protected targets simply stop toggling and read back as array
      FWSB_C_FINAL:
        if (bus.done)
          st_nxt = FWSB_C_END;
      FWSB_C_END:
        st_nxt = FWSB_C_IDLE;
      default:
        st_nxt = FWSB_C_IDLE;
    endcase
  end

  // order capture and read history
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      st_r        <= FWSB_C_IDLE;
      op_r        <= FWSB_OP_READ;
      addr_r      <= '0;
      wdata_r     <= '0;
      prev_r      <= '0;
      have_prev_r <= 1'b0;
      res_r       <= FWSB_RES_DONE;
      RDATA       <= '0;
      act_r       <= 1'b0;
      sel_r       <= 1'b0;
    end
    else
    begin
      st_r  <= st_nxt;
      res_r <= res_nxt;
      if (st_r == FWSB_C_IDLE && START)
      begin
        op_r        <= OP;
        addr_r      <= ADDR;
        wdata_r     <= WDATA;
        have_prev_r <= 1'b0;
      end
      if (bus.done && !bus.wr)
      begin
        prev_r      <= rd;
        have_prev_r <= 1'b1;
        RDATA       <= rd; // final read holds true data
        if (is_poll && have_prev_r)
        begin
          act_r <= tog1;
          sel_r <= tog2;
        end
      end
    end
  end

  // strobe engine for single bus cycles
  fwsb_strobe u_strobe (
    .clk   (CLK_SYS),
    .rst   (RESET),
    .bus   (bus.slave),
    .fa    (FA),
    .ce_n  (CE_N),
    .oe_n  (OE_N),
    .we_n  (WE_N),
    .dq_o  (DQ_O),
    .dq_oe (DQ_OE),
    .dq_i  (DQ_I)
  );

  assign BUSY            = (st_r != FWSB_C_IDLE);
  assign DONE            = (st_r == FWSB_C_END);
  assign RESULT          = res_r;
  assign ERASE_ACTIVE    = act_r;
  assign SECTOR_SELECTED = sel_r;
endmodule : fwsb_ctrl

// *** fwsb_ctrl_assertions.sv ***
// fwsb_ctrl_assertions: port checks of the flash poll controller
// assumes a bind onto fwsb_ctrl, one clock, sync reset
`timescale 1ns/1ps
module fwsb_ctrl_chk
  import fwsb_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // watched ports
  input wire logic START,
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic CE_N,
  input wire logic OE_N,
  input wire logic WE_N,
  input wire logic DQ_OE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // read and write strobe phases, two cycles each
  sequence rd_s; (!OE_N && !CE_N)[*2] ##1 (OE_N && CE_N); endsequence
  sequence wr_s; (!WE_N && DQ_OE)[*2] ##1 WE_N; endsequence
  rd_len_a:    assert property ($fell(OE_N) |-> rd_s) else $error("read strobe length wrong");
  wr_len_a:    assert property ($fell(WE_N) |-> wr_s) else $error("write strobe length wrong");
  no_clash_a:  assert property (DQ_OE |-> OE_N) else $error("bus driven during read");
  done_one_a:  assert property (DONE |=> !DONE) else $error("done longer than one cycle");
  done_busy_a: assert property (DONE |-> BUSY) else $error("done outside busy");
  take_a:      assert property (START && !BUSY |=> BUSY) else $error("order not taken");
  idle_a:      assert property (!BUSY |-> CE_N && OE_N && WE_N && !DQ_OE) else $error("strobe while idle");
  rst_a:       assert property (disable iff (1'b0) RESET |=> !BUSY && !DONE && CE_N) else $error("reset not quiet");
endmodule : fwsb_ctrl_chk

// *** fwsb_flash_model.sv ***
// fwsb_flash_model: behavioural flash answering reads with write status
// assumes strobes from fwsb_ctrl and a mode load from the bench
`timescale 1ns/1ps
module fwsb_flash_model
  import fwsb_pkg::*;
(
  // flash pins
  input  wire logic [FWSB_AW-1:0] fa,
  input  wire logic               ce_n,
  input  wire logic               oe_n,
  input  wire logic               we_n,
  input  wire logic [FWSB_DW-1:0] dq_i,
  output logic      [FWSB_DW-1:0] dq_o,
  // bench control
  input  wire logic               ld,
  input  wire logic [2:0]         md_i,
  input  wire logic [7:0]         runs_i,
  output logic      [FWSB_DW-1:0] wlat
);
  logic [2:0]         md = 3'h0;
  logic [7:0]         left = 8'h00;
  logic               t1 = 1'b0;
  logic               t2 = 1'b0;
  logic [FWSB_DW-1:0] arr = 8'hA5;
  logic [FWSB_DW-1:0] last = 8'h00;
  logic [FWSB_DW-1:0] st;
  // status byte per mode, array data when idle
  always_comb
    case (md)
      3'h1, 3'h5: st = {~wlat[7], t1, 6'h00};
      3'h2: st = {1'b0, t1, 3'h0, t2, 2'h0};
      3'h3: st = {1'b1, 1'b0, 3'h0, t2, 2'h0};
      3'h4: st = {~wlat[7], t1, 1'b1, 5'h00};
      default: st = arr;
    endcase
  // released bus shows inverse of last value
  assign dq_o = (oe_n || ce_n) ? ~last : st;
  // each finished read moves toggles, and the run count in modes 1, 2 and 5
  always @(posedge oe_n)
  begin
    last = st;
    t1 = ~t1;
    t2 = ~t2;
    if (md == 3'h1 || md == 3'h2 || md == 3'h5)
    begin
      if (left == 8'h00)
      begin
        arr = (md == 3'h1) ? wlat : (md == 3'h2) ? 8'hFF : arr;
        md = 3'h0;
      end
      else
        left = left - 8'h01;
    end
  end
  // write data latch and bench mode load
  always @(posedge we_n) wlat = dq_i;
  always @(posedge ld)
  begin
    md = md_i;
    left = runs_i;
  end
endmodule : fwsb_flash_model

// *** flash_write_status_bits_tb.sv ***
// flash_write_status_bits_tb: order sequences against the flash model
// assumes fwsb_ctrl, fwsb_flash_model and the checker bound below
`timescale 1ns/1ps
module flash_write_status_bits_tb;
  import fwsb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  fwsb_op_t op = FWSB_OP_READ;
  logic [FWSB_AW-1:0] addr = '0;
  logic [FWSB_DW-1:0] wdata = 8'h00;
  logic ld = 1'b0;
  logic [2:0] md = 3'h0;
  logic [7:0] runs = 8'h00;
  int err_count = 0;
  int checks_done = 0;
  wire BUSY, DONE, ERASE_ACTIVE, SECTOR_SELECTED, CE_N, OE_N, WE_N, DQ_OE;
  fwsb_res_t RESULT;
  wire [FWSB_DW-1:0] RDATA, DQ_O, fm_dq, fm_wlat;
  wire [FWSB_AW-1:0] FA;
  wire [FWSB_DW-1:0] dq_bus = DQ_OE ? DQ_O : fm_dq;
  // 20 MHz clock
  always #25 clk = ~clk;
  fwsb_ctrl DUT (.CLK_SYS(clk), .RESET(rst), .START(start), .OP(op), .ADDR(addr), .WDATA(wdata),
    .BUSY(BUSY), .DONE(DONE), .RESULT(RESULT), .RDATA(RDATA), .ERASE_ACTIVE(ERASE_ACTIVE),
    .SECTOR_SELECTED(SECTOR_SELECTED), .FA(FA), .CE_N(CE_N), .OE_N(OE_N), .WE_N(WE_N), .DQ_O(DQ_O),
    .DQ_OE(DQ_OE), .DQ_I(dq_bus));
  fwsb_flash_model FM (.fa(FA), .ce_n(CE_N), .oe_n(OE_N), .we_n(WE_N), .dq_i(DQ_O), .dq_o(fm_dq),
    .ld(ld), .md_i(md), .runs_i(runs), .wlat(fm_wlat));
  // verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  // one order, waits for done
  task automatic run_op(input fwsb_op_t o, input logic [FWSB_AW-1:0] a, input logic [7:0] d);
    int n;
    n = 0;
    op = o;
    addr = a;
    wdata = d;
    start = 1'b1;
    @(posedge clk);
    #5 start = 1'b0;
    while (DONE !== 1'b1 && n < 4000)
    begin
      @(posedge clk);
      #5 n++;
    end
    if (n >= 4000)
    begin
      err_count++;
      $display("unexpected hang at %0t got %h exp %h", $time, 1'b0, 1'b1);
    end
    // next order only after the done cycle, else it is refused
    @(posedge clk);
    #5;
  endtask : run_op
  // model mode load in place of a command sequence
  task automatic load(input logic [2:0] m, input logic [7:0] r);
    md = m;
    runs = r;
    #1 ld = 1'b1;
    #1 ld = 1'b0;
  endtask : load
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected byte at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_byte
  task automatic chk_addr(input logic [FWSB_AW-1:0] g, input logic [FWSB_AW-1:0] e);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected address at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_addr
  task automatic chk_res(input fwsb_res_t g, input fwsb_res_t e);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected result at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_res
  // main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    #5 rst = 1'b0;
    run_op(FWSB_OP_READ, 18'h00040, 8'h00);
    chk_byte(RDATA, 8'hA5);
    $display("test array read done");
    for (int i = 0; i < 2; i++)
    begin
      run_op(FWSB_OP_WRITE, 18'h00100, i ? 8'hC3 : 8'h3C);
      chk_byte(fm_wlat, i ? 8'hC3 : 8'h3C);
      load(3'h1, 8'h06);
      run_op(FWSB_OP_POLL_PROG, 18'h00100, i ? 8'hC3 : 8'h3C);
      chk_res(RESULT, FWSB_RES_DONE);
      chk_byte(RDATA, i ? 8'hC3 : 8'h3C);
      chk_addr(FA, 18'h00100);
    end
    $display("test program poll done");
    load(3'h2, 8'h06);
    run_op(FWSB_OP_POLL_ERASE, 18'h20000, 8'h00);
    chk_res(RESULT, FWSB_RES_DONE);
    chk_byte(RDATA, 8'hFF);
    chk_addr(FA, 18'h20000);
    chk_byte({7'h00, ERASE_ACTIVE}, 8'h00);
    $display("test erase poll done");
    load(3'h3, 8'h00);
    run_op(FWSB_OP_POLL_ERASE, 18'h20000, 8'h00);
    chk_res(RESULT, FWSB_RES_SUSP);
    chk_byte({7'h00, SECTOR_SELECTED}, 8'h01);
    chk_byte({7'h00, ERASE_ACTIVE}, 8'h00);
    $display("test suspend done");
    run_op(FWSB_OP_WRITE, 18'h00200, 8'h80);
    load(3'h4, 8'h00);
    run_op(FWSB_OP_POLL_PROG, 18'h00200, 8'h80);
    chk_res(RESULT, FWSB_RES_FAIL);
    $display("test timeout done");
    load(3'h5, 8'h04);
    run_op(FWSB_OP_POLL_PROG, 18'h00200, 8'h80);
    chk_res(RESULT, FWSB_RES_DONE);
    chk_byte(RDATA, 8'hFF);
    chk_addr(FA, 18'h00200);
    $display("test protected done");
    stop_test();
  end
  // watchdog well past the expected run
  initial
  begin
    repeat (40000) @(posedge clk);
    err_count++;
    stop_test();
  end
endmodule : flash_write_status_bits_tb
bind fwsb_ctrl fwsb_ctrl_chk chk (.CLK_SYS(CLK_SYS), .RESET(RESET), .START(START), .BUSY(BUSY), .DONE(DONE),
  .CE_N(CE_N), .OE_N(OE_N), .WE_N(WE_N), .DQ_OE(DQ_OE));
